// >>> verilog/cpo_fifo.sv
// Parameterised synchronous FIFO for the pixel output path
`timescale 1ns/1ps
module cpo_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16,
    parameter int SLACK = 3
) (
    input wire logic sys_clk, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic in_valid, // Write request
    output logic in_ready, // Room left beyond slack
    input wire logic [WIDTH-1:0] in_data, // Write word
    output logic out_valid, // Word available
    input wire logic out_ready, // Consumer takes word
    output logic [WIDTH-1:0] out_data // Head word, registered
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic [WIDTH-1:0] head;
        logic head_vld;
        logic rdy;
    } cpo_fifo_st_t;

    cpo_fifo_st_t st_reg;
    cpo_fifo_st_t st_next;
    logic push;
    logic pop;
    logic load;

    assign push = in_valid && (st_reg.count < (AW+1)'(DEPTH));
    assign load = st_reg.count != '0 && (!st_reg.head_vld || out_ready);
    assign pop = st_reg.head_vld && out_ready;
    assign in_ready = st_reg.rdy;
    assign out_valid = st_reg.head_vld;
    assign out_data = st_reg.head;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr_ptr] = in_data;
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_next.head_vld = 1'b0;
        end
        // Head register keeps read data off the memory array
        if (load) begin
            st_next.head = st_reg.mem[st_reg.rd_ptr];
            st_next.head_vld = 1'b1;
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
        st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(load);
        // Slack covers words already inside the upstream pipeline
        st_next.rdy = st_next.count < (AW+1)'(DEPTH - SLACK);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // (R07) no lost words
    chk_fifo_no_overflow: assert property (@(posedge sys_clk) disable iff (!rstn) // R07
        in_valid |-> st_reg.count < (AW+1)'(DEPTH))
        else $error("FIFO written while full");

endmodule // cpo_fifo

// >>> verilog/cpo_port.sv
// Pixel output port: test pattern, black level and gain, format, FIFO, pins
//
// Overview of operation
// (R01) Eight data lines carry processed 8-bit data, or the top eight bits of raw 10-bit data in bypass.
// (R02) In raw bypass the shared pins nine and eight carry bits 1 and 0, otherwise they are GPIO.
// (R03) The frame qualifier marks the rows that belong to the active image of the frame.
// (R04) The line qualifier marks each line of active data within a frame.
// (R05) The receiver samples data and qualifiers with the pixel clock this port drives out.
// (R06) The output format is selectable among YCbCr, RGB 565, 555, 444, JPEG 4:2:2, 4:2:0 and raw 10-bit; the code packs RGB 565 and JPEG like YCbCr.
// (R07) Outgoing data passes an output FIFO so it leaves at an even rate without bursts.
// (R08) Test mode replaces the incoming raw stream with a generated pattern chosen from several.
// (R09) Each pixel first gets black-level subtraction and then a programmable digital gain; in raw bypass the code skips both.
// (R10) The active-low master reset returns all logic to its initial state while held low.
// (R11) The standby input level moves the port into and out of low-power standby.
// (R12) Logic runs from the PLL clock or directly from the master clock with the PLL powered down.
// (R13) Data lines hold a valid pixel only while both qualifiers are high, and read zero otherwise.
package cpo_pkg;
    localparam int CLK_NS = 10;
    localparam int PCLK_NS = 20;
    localparam int PCLK_HALF = PCLK_NS / (2 * CLK_NS);
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_SLACK = 3;
    localparam int WORD_W = 12;
    localparam int POS_EOF = 11;
    localparam int POS_EOL = 10;
    localparam int GAIN_FRAC = 5;
    localparam logic [7:0] GAIN_UNITY = 8'h20;
    localparam logic [9:0] PIX_MAX = 10'h3FF;
    localparam logic [9:0] FLAT_GRAY = 10'h200;
    localparam logic [2:0] FMT_YCBCR = 3'h0;
    localparam logic [2:0] FMT_RGB565 = 3'h1;
    localparam logic [2:0] FMT_RGB555 = 3'h2;
    localparam logic [2:0] FMT_RGB444 = 3'h3;
    localparam logic [2:0] FMT_JPEG422 = 3'h4;
    localparam logic [2:0] FMT_JPEG420 = 3'h5;
    localparam logic [2:0] FMT_RAW10 = 3'h6;
    localparam logic [1:0] PAT_FLAT = 2'h0;
    localparam logic [1:0] PAT_HRAMP = 2'h1;
    localparam logic [1:0] PAT_CHECK = 2'h2;
    localparam logic [1:0] PAT_VRAMP = 2'h3;
    typedef enum logic [1:0] {ST_STANDBY, ST_IDLE, ST_RUN} cpo_mode_t;
endpackage

`timescale 1ns/1ps
module cpo_port (
    input wire logic sys_clk, // System clock, 100 MHz
    input wire logic rstn, // Master reset, active low
    input wire logic standby_pin, // Standby request pin, high = standby
    input wire logic pll_bypass_pin, // High = run straight from master clock
    output logic pll_power_down, // PLL powered down
    output logic core_clk_from_pll, // Core clock mux selects PLL
    output logic standby_active, // Port is in standby
    input wire logic raw_valid, // Raw sensor sample valid
    input wire logic [9:0] raw_data, // Raw 10-bit sample
    input wire logic raw_eol, // Last sample of a line
    input wire logic raw_eof, // Last sample of a frame
    output logic raw_ready, // Port can take samples
    input wire logic test_en, // Substitute test image
    input wire logic [1:0] test_sel, // Test pattern choice
    input wire logic [9:0] black_level, // Black level to subtract
    input wire logic [7:0] digital_gain, // Gain, unity at cpo_pkg::GAIN_UNITY
    input wire logic [2:0] fmt_sel, // Output format
    input wire logic gpio9_out, // GPIO value for pin nine
    input wire logic gpio9_oe, // GPIO enable for pin nine
    input wire logic gpio8_out, // GPIO value for pin eight
    input wire logic gpio8_oe, // GPIO enable for pin eight
    output logic [1:0] gpio_in_sync, // Pins nine and eight as read
    output logic [7:0] pixel_data_lines, // Image data out
    output logic pixel_sample_clock, // Pixel clock out
    output logic frame_valid_out, // Frame qualifier
    output logic line_valid_out, // Line qualifier
    input wire logic shared_pin_nine_bit1_i, // Pin nine input
    output logic shared_pin_nine_bit1_o, // Pin nine output
    output logic shared_pin_nine_bit1_oe, // Pin nine drive enable
    input wire logic shared_pin_eight_bit0_i, // Pin eight input
    output logic shared_pin_eight_bit0_o, // Pin eight output
    output logic shared_pin_eight_bit0_oe // Pin eight drive enable
);
    import cpo_pkg::*;

    typedef struct packed {
        logic [2:0][3:0] sync;
        logic [3:0] pin_q;
        cpo_mode_t mode;
        logic [10:0] col;
        logic [10:0] row;
        logic s1_vld;
        logic [9:0] s1_val;
        logic s1_eol;
        logic s1_eof;
        logic s2_vld;
        logic [WORD_W-1:0] s2_word;
        logic ready;
        logic [$clog2(PCLK_HALF+1)-1:0] div;
        logic pclk;
        logic in_frame;
        logic fv;
        logic lv;
        logic [7:0] dout;
        logic [1:0] lsb;
        logic bypass;
        logic pll_pd;
    } cpo_st_t;

    cpo_st_t st_reg;
    cpo_st_t st_next;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;
    logic standby_q;
    logic edge_now;
    logic [9:0] src_val;
    logic [9:0] sub_val;
    logic [17:0] product;
    logic [12:0] scaled;
    logic [9:0] gained;
    logic [7:0] fmt_byte;

    assign standby_q = st_reg.pin_q[0];
    // Data moves only on the falling pixel clock edge
    assign edge_now = st_reg.mode != ST_STANDBY && st_reg.pclk &&
        st_reg.div == '0;
    assign fifo_out_ready = edge_now;

    ////////////////////////////////////////////////////////////////////////////
    // Datapath front end
    always_comb begin
        // (R08) test image select
        case (test_sel)
            PAT_FLAT: src_val = FLAT_GRAY;
            PAT_HRAMP: src_val = st_reg.col[9:0];
            PAT_CHECK: src_val = (st_reg.col[3] ^ st_reg.row[3]) ? PIX_MAX : 10'h000;
            default: src_val = st_reg.row[9:0];
        endcase
        if (!test_en) begin
            src_val = raw_data;
        end
        // (R09) black level, then gain
        sub_val = (st_reg.s1_val > black_level) ? st_reg.s1_val - black_level : 10'h000;
        product = sub_val * digital_gain;
        scaled = product[17:GAIN_FRAC];
        gained = (scaled > 13'(PIX_MAX)) ? PIX_MAX : scaled[9:0];
        // (R06) format packing of the processed byte
        case (fmt_sel)
            FMT_RGB555: fmt_byte = {1'b0, gained[9:3]};
            FMT_RGB444: fmt_byte = {gained[9:6], 4'h0};
            default: fmt_byte = gained[9:2];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;
        // Pins pass three flops; a change counts once stages two and three agree
        st_next.sync[0] = {standby_pin, pll_bypass_pin, shared_pin_nine_bit1_i,
            shared_pin_eight_bit0_i};
        st_next.sync[1] = st_reg.sync[0];
        st_next.sync[2] = st_reg.sync[1];
        for (int i = 0; i < 4; i++) begin
            if (st_reg.sync[1][i] == st_reg.sync[2][i]) begin
                st_next.pin_q[i] = st_reg.sync[2][i];
            end
        end
        // (R12) PLL bypass powers the PLL down
        st_next.pll_pd = st_reg.pin_q[2];
        st_next.bypass = fmt_sel == FMT_RAW10;

        // (R11) standby mode control
        case (st_reg.mode)
            ST_STANDBY: begin
                if (!st_reg.pin_q[3]) begin
                    st_next.mode = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (st_reg.pin_q[3]) begin
                    st_next.mode = ST_STANDBY;
                end else if (raw_valid) begin
                    st_next.mode = ST_RUN;
                end
            end
            default: begin
                // Standby waits for the frame in flight to drain
                // Qualifiers must be low first so standby never shows them high
                if (st_reg.pin_q[3] && !st_reg.in_frame && !fifo_out_valid &&
                    !st_reg.s1_vld && !st_reg.s2_vld && !st_reg.fv && !st_reg.lv) begin
                    st_next.mode = ST_STANDBY;
                end
            end
        endcase

        // Front pipeline, only fed while ready is shown
        st_next.s1_vld = raw_valid && st_reg.ready;
        if (raw_valid && st_reg.ready) begin
            st_next.s1_val = src_val;
            st_next.s1_eol = raw_eol;
            st_next.s1_eof = raw_eof;
            st_next.col = raw_eol ? 11'h000 : st_reg.col + 11'h001;
            if (raw_eof) begin
                st_next.row = 11'h000;
            end else if (raw_eol) begin
                st_next.row = st_reg.row + 11'h001;
            end
        end
        st_next.s2_vld = st_reg.s1_vld;
        if (st_reg.s1_vld) begin
            // (R01) raw bypass keeps all ten bits, else processed byte
            st_next.s2_word = st_reg.bypass ?
                {st_reg.s1_eof, st_reg.s1_eol, st_reg.s1_val} :
                {st_reg.s1_eof, st_reg.s1_eol, fmt_byte, 2'b00};
        end
        st_next.ready = fifo_in_ready && st_reg.mode != ST_STANDBY && !st_reg.pin_q[3];

        // (R05) pixel clock out, divided from the system clock
        if (st_reg.mode == ST_STANDBY) begin
            st_next.pclk = 1'b0;
            st_next.div = '0;
        end else if (st_reg.div == '0) begin
            st_next.pclk = !st_reg.pclk;
            st_next.div = $bits(st_reg.div)'(PCLK_HALF - 1);
        end else begin
            st_next.div = st_reg.div - 1'b1;
        end

        // (R07) one FIFO word per pixel clock, gaps drop the line qualifier
        if (st_reg.mode == ST_STANDBY) begin
            st_next.fv = 1'b0;
            st_next.lv = 1'b0;
            st_next.dout = 8'h00;
            st_next.lsb = 2'b00;
            st_next.in_frame = 1'b0;
        end else if (edge_now) begin
            // (R03) (R04) qualifiers follow FIFO words
            st_next.lv = fifo_out_valid;
            st_next.fv = fifo_out_valid || st_reg.in_frame;
            if (fifo_out_valid) begin
                st_next.in_frame = !fifo_out_data[POS_EOF];
            end
            // (R13) data zero outside qualified pixels
            st_next.dout = fifo_out_valid ? fifo_out_data[9:2] : 8'h00;
            st_next.lsb = fifo_out_valid ? fifo_out_data[1:0] : 2'b00;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        // (R10) async master reset
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    cpo_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH),
        .SLACK(FIFO_SLACK)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(st_reg.s2_vld),
        .in_ready(fifo_in_ready),
        .in_data(st_reg.s2_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign pll_power_down = st_reg.pll_pd;
    assign core_clk_from_pll = !st_reg.pll_pd;
    assign standby_active = st_reg.mode == ST_STANDBY;
    assign raw_ready = st_reg.ready;
    assign gpio_in_sync = st_reg.pin_q[1:0];
    assign pixel_data_lines = st_reg.dout;
    assign pixel_sample_clock = st_reg.pclk;
    assign frame_valid_out = st_reg.fv;
    assign line_valid_out = st_reg.lv;
    // (R02) shared pins: low data bits in bypass, GPIO otherwise
    assign shared_pin_nine_bit1_o = st_reg.bypass ? st_reg.lsb[1] : gpio9_out;
    assign shared_pin_nine_bit1_oe = st_reg.bypass || gpio9_oe;
    assign shared_pin_eight_bit0_o = st_reg.bypass ? st_reg.lsb[0] : gpio8_out;
    assign shared_pin_eight_bit0_oe = st_reg.bypass || gpio8_oe;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_flat_taken;
        raw_valid && raw_ready && test_en && test_sel == PAT_FLAT;
    endsequence

    chk_lv_inside_fv: assert property (line_valid_out |-> frame_valid_out) // R03 R04
        else $error("Line qualifier outside frame");
    chk_data_idle_zero: assert property (!line_valid_out |-> pixel_data_lines == 8'h00) // R13
        else $error("Data lines not zero outside line");
    chk_data_at_fall: assert property ($changed(pixel_data_lines) |-> !pixel_sample_clock) // R05
        else $error("Data changed away from falling clock");
    chk_pclk_runs: assert property (!standby_active [*2] |-> pixel_sample_clock != $past(pixel_sample_clock)) // R05
        else $error("Pixel clock stalled");
    chk_standby_quiet: assert property (standby_active |-> !frame_valid_out && !line_valid_out && !raw_ready) // R11
        else $error("Activity in standby");
    chk_bypass_pins: assert property (st_reg.bypass |-> shared_pin_nine_bit1_oe && shared_pin_eight_bit0_oe) // R02
        else $error("Shared pins not driven in bypass");
    chk_pll_follows: assert property ($rose(st_reg.pin_q[2]) |=> pll_power_down && !core_clk_from_pll) // R12
        else $error("PLL not powered down on bypass");
    chk_test_flat: assert property (s_flat_taken |=> st_reg.s1_val == FLAT_GRAY) // R08
        else $error("Flat test pattern not substituted");
    chk_gain_unity: assert property (st_reg.s1_vld && !st_reg.bypass && digital_gain == GAIN_UNITY &&
        black_level == 10'h000 && fmt_sel == FMT_YCBCR |=> st_reg.s2_word[9:2] == $past(st_reg.s1_val[9:2])) // R09
        else $error("Unity gain altered pixel");

endmodule // cpo_port

// >>> tb/cpo_host_rx.sv
// Host receiver model: captures pixels on the rising pixel clock
`timescale 1ns/1ps
module cpo_host_rx (
    input wire logic pixel_sample_clock, // Pixel clock from the port
    input wire logic frame_valid_out, // Frame qualifier
    input wire logic line_valid_out, // Line qualifier
    input wire logic [7:0] pixel_data_lines, // Image data
    input wire logic pin_nine, // Level on shared pin nine
    input wire logic pin_eight // Level on shared pin eight
);
    logic [9:0] seen[$];
    int n_lines = 0;
    int n_frames = 0;
    int n_idle_dirty = 0;
    logic lv_q = 1'b0;
    logic fv_q = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // sample inside qualifiers
    always @(posedge pixel_sample_clock) begin
        if (frame_valid_out && line_valid_out) begin
            seen.push_back({pixel_data_lines, pin_nine, pin_eight});
        end else if (pixel_data_lines !== 8'h00) begin
            n_idle_dirty++;
        end
        if (line_valid_out && !lv_q) begin
            n_lines++;
        end
        if (!frame_valid_out && fv_q) begin
            n_frames++;
        end
        lv_q = line_valid_out;
        fv_q = frame_valid_out;
    end
endmodule // cpo_host_rx

// >>> tb/cpo_port_test.sv
// Self-checking bench for the pixel output port
`timescale 1ns/1ps
module cpo_port_test;
    import cpo_pkg::*;
    logic sys_clk, rstn, standby_pin, pll_bypass_pin, raw_valid, raw_eol, raw_eof, test_en;
    logic [9:0] raw_data, black_level;
    logic [1:0] test_sel, gpio_in_sync;
    logic [7:0] digital_gain, pixel_data_lines;
    logic [2:0] fmt_sel;
    logic gpio9_out, gpio9_oe, gpio8_out, gpio8_oe, ext9, ext8, pin9, pin8;
    logic pll_power_down, core_clk_from_pll, standby_active, raw_ready, pixel_sample_clock;
    logic frame_valid_out, line_valid_out, nine_o, nine_oe, eight_o, eight_oe;
    int miscompares = 0;
    int n_compared = 0;
    int n_wait = 0;
    logic [9:0] exp_q[$];

    // Undriven pins read the outside driver
    assign pin9 = nine_oe ? nine_o : ext9;
    assign pin8 = eight_oe ? eight_o : ext8;

    cpo_port u_dut (.sys_clk(sys_clk), .rstn(rstn), .standby_pin(standby_pin),
        .pll_bypass_pin(pll_bypass_pin), .pll_power_down(pll_power_down),
        .core_clk_from_pll(core_clk_from_pll), .standby_active(standby_active),
        .raw_valid(raw_valid), .raw_data(raw_data), .raw_eol(raw_eol), .raw_eof(raw_eof),
        .raw_ready(raw_ready), .test_en(test_en), .test_sel(test_sel),
        .black_level(black_level), .digital_gain(digital_gain), .fmt_sel(fmt_sel),
        .gpio9_out(gpio9_out), .gpio9_oe(gpio9_oe), .gpio8_out(gpio8_out),
        .gpio8_oe(gpio8_oe), .gpio_in_sync(gpio_in_sync),
        .pixel_data_lines(pixel_data_lines), .pixel_sample_clock(pixel_sample_clock),
        .frame_valid_out(frame_valid_out), .line_valid_out(line_valid_out),
        .shared_pin_nine_bit1_i(pin9), .shared_pin_nine_bit1_o(nine_o),
        .shared_pin_nine_bit1_oe(nine_oe), .shared_pin_eight_bit0_i(pin8),
        .shared_pin_eight_bit0_o(eight_o), .shared_pin_eight_bit0_oe(eight_oe));

    cpo_host_rx u_rx (.pixel_sample_clock(pixel_sample_clock),
        .frame_valid_out(frame_valid_out), .line_valid_out(line_valid_out),
        .pixel_data_lines(pixel_data_lines), .pin_nine(pin9), .pin_eight(pin8));

    ////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp10(input logic [9:0] got, input logic [9:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp, input string what);
        cmp10({9'h000, got}, {9'h000, exp}, what);
    endtask

    function automatic logic [9:0] proc(input logic [9:0] r);
        int x;
        x = (r > black_level) ? int'(r) - int'(black_level) : 0;
        x = (x * int'(digital_gain)) >>> GAIN_FRAC;
        if (x > int'(PIX_MAX)) x = int'(PIX_MAX);
        return x[9:0];
    endfunction

    // Pins carry GPIO outside raw mode, so low two bits are masked
    function automatic logic [9:0] fmt_word(input logic [9:0] v);
        case (fmt_sel)
            FMT_RGB555: return {1'b0, v[9:3], 2'b00};
            FMT_RGB444: return {v[9:6], 4'h0, 2'b00};
            FMT_RAW10: return v;
            default: return {v[9:2], 2'b00};
        endcase
    endfunction

    // Raise a sample only when ready is already high, so the next edge takes it
    task automatic send(input logic [9:0] d, input logic eol, input logic eof);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (raw_ready !== 1'b1 && n < 200) begin
            raw_valid = 1'b0;
            n++;
            n_wait++;
            @(negedge sys_clk);
        end
        if (n == 200) cmp1(1'b0, 1'b1, "ready timeout");
        raw_valid = 1'b1;
        raw_data = d;
        raw_eol = eol;
        raw_eof = eof;
    endtask

    task automatic run(input int lines, input int px, input logic [9:0] base,
                       input logic [9:0] step);
        int l0, f0, n, i;
        logic [9:0] v, got, e, s0;
        l0 = u_rx.n_lines;
        f0 = u_rx.n_frames;
        v = base;
        for (int l = 0; l < lines; l++) begin
            for (int p = 0; p < px; p++) begin
                send(v, p == px - 1, p == px - 1 && l == lines - 1);
                // Raw bypass skips black level and gain
                e = test_en ? FLAT_GRAY : v;
                exp_q.push_back(fmt_word(fmt_sel == FMT_RAW10 ? e : proc(e)));
                v = v + step;
            end
            @(negedge sys_clk);
            raw_valid = 1'b0;
            repeat (2 * px + 20) @(negedge sys_clk);
        end
        n = 0;
        while (u_rx.n_frames == f0 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        cmp10(10'(u_rx.seen.size()), 10'(lines * px), "pixel count");
        i = 0;
        s0 = 10'h000;
        while (u_rx.seen.size() > 0 && exp_q.size() > 0) begin
            got = u_rx.seen.pop_front();
            e = exp_q.pop_front();
            if (fmt_sel !== FMT_RAW10) got[1:0] = 2'b00;
            if (i == 0) s0 = got;
            // Checker: first 8 columns one level, next 8 the other
            if (test_en && test_sel == PAT_CHECK) e = (i < 8) ? s0 : ~s0;
            cmp10(got, e, "pixel value");
            i++;
        end
        if (test_en && test_sel == PAT_CHECK) cmp1(s0 == 10'h000 || s0 == PIX_MAX, 1'b1, "check");
        exp_q.delete();
        u_rx.seen.delete();
        cmp10(10'(u_rx.n_lines - l0), 10'(lines), "line count");
        cmp10(10'(u_rx.n_frames - f0), 10'h001, "frame count");
    endtask

    task automatic reset_check(input int hold);
        @(negedge sys_clk);
        rstn = 1'b0;
        raw_valid = 1'b0;
        #1;
        cmp10({pixel_data_lines, frame_valid_out, line_valid_out}, 10'h000, "reset out");
        cmp10({8'h00, raw_ready, pixel_sample_clock}, 10'h000, "reset ready");
        repeat (hold) @(negedge sys_clk);
        rstn = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        #500000;
        miscompares++;
        results();
    end

    initial begin
        int n;
        rstn = 1'b0;
        {standby_pin, pll_bypass_pin, raw_valid, raw_eol, raw_eof, test_en} = 6'h00;
        raw_data = 10'h000;
        black_level = 10'h000;
        test_sel = PAT_FLAT;
        digital_gain = GAIN_UNITY;
        fmt_sel = FMT_YCBCR;
        {gpio9_out, gpio9_oe, gpio8_out, gpio8_oe, ext9, ext8} = 6'b110001;
        reset_check(12);
        for (int f = 0; f < 8; f++) begin
            fmt_sel = 3'(f);
            run(2, 4, 10'h0F3, 10'h0A7);
        end
        repeat (6) @(negedge sys_clk);
        cmp10({6'h00, nine_oe, nine_o, eight_oe, gpio_in_sync[0]}, 10'h00D, "gpio pins");
        cmp10({8'h00, gpio_in_sync}, 10'h003, "gpio read");
        fmt_sel = FMT_YCBCR;
        black_level = 10'h040;
        digital_gain = 8'h40;
        run(1, 5, 10'h040, 10'h0C0);
        fmt_sel = FMT_RAW10;
        repeat (2) @(negedge sys_clk);
        cmp1(eight_oe, 1'b1, "raw pin drive");
        black_level = 10'h000;
        digital_gain = GAIN_UNITY;
        test_en = 1'b1;
        run(1, 4, 10'h123, 10'h011);
        test_sel = PAT_CHECK;
        run(1, 16, 10'h000, 10'h001);
        test_en = 1'b0;
        n_wait = 0;
        run(1, 40, 10'h001, 10'h019);
        cmp1(n_wait > 0, 1'b1, "fifo refusal");
        repeat (3) send(10'h155, 1'b0, 1'b0);
        reset_check(3);
        repeat (20) @(negedge sys_clk);
        standby_pin = 1'b1;
        n = 0;
        while (standby_active !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        repeat (4) @(negedge sys_clk);
        cmp10({7'h00, standby_active, raw_ready, pixel_sample_clock}, 10'h004, "standby");
        standby_pin = 1'b0;
        repeat (12) @(negedge sys_clk);
        cmp10({8'h00, standby_active, raw_ready}, 10'h001, "wake");
        pll_bypass_pin = 1'b1;
        repeat (10) @(negedge sys_clk);
        cmp10({8'h00, pll_power_down, core_clk_from_pll}, 10'h002, "pll off");
        pll_bypass_pin = 1'b0;
        repeat (10) @(negedge sys_clk);
        cmp10({8'h00, pll_power_down, core_clk_from_pll}, 10'h001, "pll on");
        cmp10(10'(u_rx.n_idle_dirty), 10'h000, "idle data");
        results();
    end
endmodule // cpo_port_test
